// ---- hdl/frw_channel.sv ----
// Flexible disk read/write channel control with APB registers
//
// How it works
// - Write path enabled only with write gate, drive selected, disk unprotected.
// - Write flip-flop toggles per data pulse, steering current between windings.
// - Erase enable follows write gate changes after a fixed delay.
// - Host keeps write gate off when reading; read circuits on only then.
// - Head coils leave the read chain while write mode is active.
// - Every comparator transition with write gate off fires the time-domain one-shot.
// - One-shot trailing edge loads comparator state into the filter flip-flop unless the event buffer is full.
// - Each filter flip-flop transition yields one 500 ns low read pulse.
// - Supply fail blocks write and erase current regardless of enables.
// - Power-up init pulse of 40 ms resets erase delay and activity latch.
// - Head loads from select without option, else from head engage.
// - Side low selects head 0, side high selects head 1.
// - Write protect inhibit forces write enable off despite write gate.
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "frw_defs.svh"
module frw_channel
	import frw_pkg::*;
#(
	parameter int unsigned INIT_CYC = `FRW_INIT_CYC,
	parameter int unsigned ERASE_DLY_CYC = `FRW_ERASE_DLY_CYC,
	parameter int unsigned TD_CYC = `FRW_TD_CYC,
	parameter int unsigned RD_PULSE_CYC = `FRW_RD_PULSE_CYC,
	parameter int unsigned BUF_DEPTH = 2,
	parameter int unsigned BUF_WIDTH = 1
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`FRW_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic write_gate_n,
	input wire logic select_n,
	input wire logic write_data_n,
	input wire logic head_engage_n,
	input wire logic side,
	input wire logic notch_open,
	input wire logic comparator,
	input wire logic supply_fail_flag,
	output logic write_path_enable_n,
	output logic head_w1_on,
	output logic head_w2_on,
	output logic erase_drive_enable_n,
	output logic erase_current_on,
	output logic read_enable,
	output logic read_connect,
	output logic head_select,
	output logic head_load,
	output logic read_data_n,
	output logic power_up_init_n,
	output logic activity_latch
);
	localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
	localparam int CNT_W = $clog2(BUF_DEPTH + 1);

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [`FRW_NSYNC-1:0] sync1_reg;
	logic [`FRW_NSYNC-1:0] sync2_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= `FRW_SYNC_RST;
			sync2_reg <= `FRW_SYNC_RST;
		end else begin
			sync1_reg <= {supply_fail_flag, comparator, notch_open, side,
				head_engage_n, write_data_n, select_n, write_gate_n};
			sync2_reg <= sync1_reg;
		end
	end

	logic gate_on, sel_on, wd_s, eng_on, side_s, notch_s, comp_s, sfail;
	assign gate_on = !sync2_reg[0];
	assign sel_on = !sync2_reg[1];
	assign wd_s = sync2_reg[2];
	assign eng_on = !sync2_reg[3];
	assign side_s = sync2_reg[4];
	assign notch_s = sync2_reg[5];
	assign comp_s = sync2_reg[6];
	assign sfail = sync2_reg[7];

	////////////////////////////////////////////////////////////////////
	// Power-up initialization and one-shots
	logic started_reg;
	logic init_act, init_active;
	logic es_trig, es_done;
	logic td_trig, td_act, td_done;
	logic rp_trig, rp_act;
	logic gate_prev_reg, wd_prev_reg, comp_prev_reg;
	logic [`FRW_CTRL_W-1:0] ctrl_reg;
	logic inhibit, wpe;

	// Init runs from reset release until the one-shot expires
	assign init_active = !started_reg || init_act;

	frw_one_shot #(.CYCLES(INIT_CYC)) u_init (
		.pclk(pclk), .presetn(presetn), .clear(1'b0),
		.trig(!started_reg), .active(init_act), .done());
	frw_one_shot #(.CYCLES(ERASE_DLY_CYC)) u_erase (
		.pclk(pclk), .presetn(presetn), .clear(init_active),
		.trig(es_trig), .active(), .done(es_done));
	frw_one_shot #(.CYCLES(TD_CYC)) u_td (
		.pclk(pclk), .presetn(presetn), .clear(1'b0),
		.trig(td_trig), .active(td_act), .done(td_done));
	frw_one_shot #(.CYCLES(RD_PULSE_CYC)) u_rd (
		.pclk(pclk), .presetn(presetn), .clear(1'b0),
		.trig(rp_trig), .active(rp_act), .done());

	// Write protect jumper evaluation and write path qualification
	assign inhibit = ctrl_reg[`FRW_CTRL_WPPOL] ? notch_s : !notch_s;
	assign wpe = gate_on && sel_on && !inhibit && !init_active;
	assign es_trig = (gate_on != gate_prev_reg);
	assign td_trig = (comp_s != comp_prev_reg) && !gate_on;

	////////////////////////////////////////////////////////////////////
	// Event buffer between filter flip-flop and read pulse generator
	logic [BUF_WIDTH-1:0] buf_mem [BUF_DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg, rd_ptr_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic buf_ready, buf_valid, push, pop;
	logic filt_reg, filt_next;

	assign buf_ready = (cnt_reg != CNT_W'(BUF_DEPTH));
	assign buf_valid = (cnt_reg != '0);
	// Trailing edge loads comparator state, skipped when buffer is full
	assign filt_next = (td_done && buf_ready) ? comp_s : filt_reg;
	assign push = (filt_next != filt_reg);
	assign pop = buf_valid && !rp_act;
	assign rp_trig = pop;

	// Buffer storage and pointers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg <= '0;
			for (int i = 0; i < BUF_DEPTH; i++) begin
				buf_mem[i] <= '0;
			end
		end else begin
			if (push) begin
				buf_mem[wr_ptr_reg] <= BUF_WIDTH'(filt_next);
				wr_ptr_reg <= (wr_ptr_reg == PTR_W'(BUF_DEPTH - 1)) ?
					'0 : PTR_W'(wr_ptr_reg + 1'b1);
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == PTR_W'(BUF_DEPTH - 1)) ?
					'0 : PTR_W'(rd_ptr_reg + 1'b1);
			end
			cnt_reg <= CNT_W'(cnt_reg + CNT_W'(push) - CNT_W'(pop));
		end
	end

	////////////////////////////////////////////////////////////////////
	// Channel state and pin outputs
	logic wff_reg, wff_next;
	logic wpe_n_reg, wpe_n_next, w1_reg, w1_next, w2_reg, w2_next;
	logic erase_n_reg, erase_n_next, ecur_reg, ecur_next;
	logic rden_reg, rden_next, rconn_reg, rconn_next;
	logic hsel_reg, hsel_next, hload_reg, hload_next;
	logic rdn_reg, rdn_next, init_n_reg, act_reg, act_next;
	logic wd_fall;

	assign wd_fall = wd_prev_reg && !wd_s;

	// Next values of the write, erase and read controls
	always_comb begin
		wff_next = wff_reg;
		if (init_active) begin
			wff_next = 1'b0;
		end else if (wd_fall && wpe) begin
			wff_next = !wff_reg;
		end
		wpe_n_next = !wpe;
		w1_next = wpe && wff_reg && !sfail;
		w2_next = wpe && !wff_reg && !sfail;
		erase_n_next = erase_n_reg;
		if (init_active) begin
			erase_n_next = 1'b1;
		end else if (es_done) begin
			erase_n_next = !(gate_on && sel_on && !inhibit);
		end
		ecur_next = !erase_n_reg && !sfail;
		rden_next = !gate_on;
		rconn_next = !wpe;
		hsel_next = side_s;
		hload_next = ctrl_reg[`FRW_CTRL_HLOPT] ? eng_on : sel_on;
		act_next = init_active ? 1'b0 : (act_reg || (sel_on && hload_reg));
		rdn_next = !rp_act;
	end

	// Channel registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			started_reg <= 1'b0;
			gate_prev_reg <= 1'b0;
			wd_prev_reg <= 1'b1;
			comp_prev_reg <= 1'b0;
			filt_reg <= 1'b0;
			wff_reg <= 1'b0;
			wpe_n_reg <= 1'b1;
			w1_reg <= 1'b0;
			w2_reg <= 1'b0;
			erase_n_reg <= 1'b1;
			ecur_reg <= 1'b0;
			rden_reg <= 1'b0;
			rconn_reg <= 1'b0;
			hsel_reg <= 1'b0;
			hload_reg <= 1'b0;
			act_reg <= 1'b0;
			rdn_reg <= 1'b1;
			init_n_reg <= 1'b0;
		end else begin
			started_reg <= 1'b1;
			gate_prev_reg <= gate_on;
			wd_prev_reg <= wd_s;
			comp_prev_reg <= comp_s;
			filt_reg <= filt_next;
			wff_reg <= wff_next;
			wpe_n_reg <= wpe_n_next;
			w1_reg <= w1_next;
			w2_reg <= w2_next;
			erase_n_reg <= erase_n_next;
			ecur_reg <= ecur_next;
			rden_reg <= rden_next;
			rconn_reg <= rconn_next;
			hsel_reg <= hsel_next;
			hload_reg <= hload_next;
			act_reg <= act_next;
			rdn_reg <= rdn_next;
			init_n_reg <= !init_active;
		end
	end

	////////////////////////////////////////////////////////////////////
	// APB slave: one wait-free access phase, error on unmapped address
	frw_sel_t sel;
	logic pready_reg, pready_next, pslverr_reg, pslverr_next;
	logic ovf_reg, ovf_next;
	logic [`FRW_CTRL_W-1:0] ctrl_next;
	frw_word_t prdata_reg, prdata_next, status;
	logic wr_done;

	assign sel = frw_decode(paddr);
	assign wr_done = psel && penable && pready_reg && pwrite;

	// Status word assembly
	always_comb begin
		status = '0;
		status[`FRW_ST_WPE] = !wpe_n_reg;
		status[`FRW_ST_ERASE] = !erase_n_reg;
		status[`FRW_ST_WFF] = wff_reg;
		status[`FRW_ST_FILT] = filt_reg;
		status[`FRW_ST_SIDE] = hsel_reg;
		status[`FRW_ST_SFAIL] = sfail;
		status[`FRW_ST_INIT] = init_active;
		status[`FRW_ST_ACT] = act_reg;
		status[`FRW_ST_OVF] = ovf_reg;
		status[`FRW_ST_HEAD] = buf_valid && buf_mem[rd_ptr_reg][0];
	end

	// Bus next values; overflow set wins over its clear
	always_comb begin
		pready_next = psel && !penable;
		pslverr_next = psel && !penable && (sel == FRW_SEL_NONE);
		prdata_next = '0;
		if (psel && !penable && !pwrite) begin
			case (sel)
				FRW_SEL_CTRL: prdata_next = 32'(ctrl_reg);
				FRW_SEL_STATUS: prdata_next = status;
				default: prdata_next = '0;
			endcase
		end
		ctrl_next = ctrl_reg;
		if (wr_done && sel == FRW_SEL_CTRL) begin
			ctrl_next = pwdata[`FRW_CTRL_W-1:0];
		end
		ovf_next = ovf_reg;
		if (wr_done && sel == FRW_SEL_STATUS && pwdata[`FRW_ST_OVF]) begin
			ovf_next = 1'b0;
		end
		if (td_done && !buf_ready && comp_s != filt_reg) begin
			ovf_next = 1'b1;
		end
	end

	// Bus registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= '0;
			ctrl_reg <= `FRW_CTRL_RST;
			ovf_reg <= 1'b0;
		end else begin
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg <= prdata_next;
			ctrl_reg <= ctrl_next;
			ovf_reg <= ovf_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign write_path_enable_n = wpe_n_reg;
	assign head_w1_on = w1_reg;
	assign head_w2_on = w2_reg;
	assign erase_drive_enable_n = erase_n_reg;
	assign erase_current_on = ecur_reg;
	assign read_enable = rden_reg;
	assign read_connect = rconn_reg;
	assign head_select = hsel_reg;
	assign head_load = hload_reg;
	assign read_data_n = rdn_reg;
	assign power_up_init_n = init_n_reg;
	assign activity_latch = act_reg;

	////////////////////////////////////////////////////////////////////
	// Checks
	int rd_low_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_low_cnt <= 0;
		end else begin
			rd_low_cnt <= rdn_reg ? 0 : rd_low_cnt + 1;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_write_pulse;
		wd_fall && wpe && !init_active;
	endsequence
	sequence s_trailing_load;
		td_done && buf_ready;
	endsequence

	AST_WPE_GATED: assert property (!wpe_n_reg |->
		$past(gate_on && sel_on && !inhibit))
		else $error("write path enabled without qualification");
	AST_WFF_TOGGLE: assert property (s_write_pulse |=>
		wff_reg != $past(wff_reg))
		else $error("write flip-flop did not toggle");
	AST_HEAD_EXCL: assert property (!(w1_reg && w2_reg))
		else $error("both windings driven");
	AST_ERASE_DELAY: assert property ($changed(erase_n_reg) &&
		!$past(init_active) |-> $past(es_done))
		else $error("erase enable changed without delay expiry");
	AST_READ_GATE: assert property (rden_reg |-> !$past(gate_on))
		else $error("read enabled with write gate on");
	AST_READ_CONN: assert property (!wpe_n_reg |-> !rconn_reg)
		else $error("head connected to read chain in write mode");
	AST_TD_FIRE: assert property (td_trig |=> td_act [*2])
		else $error("time-domain one-shot not fired");
	AST_FILT_LOAD: assert property (s_trailing_load |=>
		filt_reg == $past(comp_s))
		else $error("filter flip-flop not loaded at trailing edge");
	AST_FILT_HOLD: assert property ($changed(filt_reg) |->
		$past(td_done))
		else $error("filter flip-flop changed early");
	AST_RD_WIDTH: assert property ($rose(rdn_reg) |->
		rd_low_cnt == RD_PULSE_CYC)
		else $error("read pulse width wrong");
	AST_SUPPLY: assert property (sfail |=>
		!w1_reg && !w2_reg && !ecur_reg)
		else $error("current flows during supply fail");
	AST_INIT_CLEAR: assert property (init_active |=>
		erase_n_reg && !wff_reg && !act_reg && !init_n_reg)
		else $error("init did not clear state");
	AST_HEAD_LOAD: assert property (!ctrl_reg[`FRW_CTRL_HLOPT] &&
		sel_on |=> hload_reg)
		else $error("head not loaded on select");
endmodule

// ---- hdl/frw_defs.svh ----
// Constants of the read/write channel controller: offsets, fields, timing
`ifndef FRW_DEFS_SVH
`define FRW_DEFS_SVH

// Clock rate
`define FRW_CLK_MHZ 100

// Register byte offsets
`define FRW_ADDR_W 12
`define FRW_OFF_CTRL 12'h000
`define FRW_OFF_STATUS 12'h004

// Control register fields and reset value
`define FRW_CTRL_W 2
`define FRW_CTRL_HLOPT 0
`define FRW_CTRL_WPPOL 1
`define FRW_CTRL_RST 2'h0

// Status register fields
`define FRW_ST_WPE 0
`define FRW_ST_ERASE 1
`define FRW_ST_WFF 2
`define FRW_ST_FILT 3
`define FRW_ST_SIDE 4
`define FRW_ST_SFAIL 5
`define FRW_ST_INIT 6
`define FRW_ST_ACT 7
`define FRW_ST_OVF 8
`define FRW_ST_HEAD 9

// Pin synchroniser width and idle levels
`define FRW_NSYNC 8
`define FRW_SYNC_RST 8'h0F

// Times in their own units and derived cycle counts
`define FRW_TD_NS 2000
`define FRW_TD_CYC ((`FRW_TD_NS * `FRW_CLK_MHZ) / 1000)
`define FRW_RD_PULSE_NS 500
`define FRW_RD_PULSE_CYC ((`FRW_RD_PULSE_NS * `FRW_CLK_MHZ) / 1000)
`define FRW_INIT_MS 40
`define FRW_INIT_CYC (`FRW_INIT_MS * 1000 * `FRW_CLK_MHZ)
`define FRW_ERASE_DLY_US 100
`define FRW_ERASE_DLY_CYC (`FRW_ERASE_DLY_US * `FRW_CLK_MHZ)

`endif

// ---- hdl/frw_one_shot.sv ----
// Retriggerable counting one-shot with trailing-edge pulse
`timescale 1ns/1ps
module frw_one_shot
	import frw_pkg::*;
#(
	parameter int unsigned CYCLES = 1
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	input wire logic trig,
	output logic active,
	output logic done
);
	localparam int W = $clog2(CYCLES + 1);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	logic active_reg;
	logic active_next;
	logic done_reg;
	logic done_next;

	// Reload on trigger, count down, flag the last count
	always_comb begin
		cnt_next = cnt_reg;
		done_next = 1'b0;
		if (clear) begin
			cnt_next = '0;
		end else if (trig) begin
			cnt_next = W'(CYCLES);
		end else if (cnt_reg != '0) begin
			cnt_next = cnt_reg - 1'b1;
			done_next = (cnt_reg == W'(1));
		end
		active_next = (cnt_next != '0);
	end

	// State registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
			active_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			active_reg <= active_next;
			done_reg <= done_next;
		end
	end

	assign active = active_reg;
	assign done = done_reg;
endmodule

// ---- hdl/frw_pkg.sv ----
// Types and address decode of the read/write channel controller
`include "frw_defs.svh"
package frw_pkg;
	typedef logic [31:0] frw_word_t;
	typedef enum logic [1:0] {
		FRW_SEL_CTRL,
		FRW_SEL_STATUS,
		FRW_SEL_NONE
	} frw_sel_t;

	// Maps a byte address onto a register
	function automatic frw_sel_t frw_decode(input logic [`FRW_ADDR_W-1:0] a);
		frw_sel_t s;
		s = FRW_SEL_NONE;
		if (a == `FRW_OFF_CTRL) begin
			s = FRW_SEL_CTRL;
		end else if (a == `FRW_OFF_STATUS) begin
			s = FRW_SEL_STATUS;
		end
		return s;
	endfunction
endpackage

// ---- tb/frw_host_model.sv ----
// Host disk controller model driving the drive interface pins
`timescale 1ns/1ps
module frw_host_model (
	input wire logic pclk,
	output logic write_gate_n,
	output logic select_n,
	output logic write_data_n,
	output logic head_engage_n,
	output logic side,
	output logic comparator
);
	// Idle interface: every line released
	initial begin
		write_gate_n = 1'b1;
		select_n = 1'b1;
		write_data_n = 1'b1;
		head_engage_n = 1'b1;
		side = 1'b0;
		comparator = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Drive select, needed for write and for head load without the option
	task automatic pin_sel(input logic on);
		@(posedge pclk);
		select_n <= !on;
	endtask

	// Write window, kept off whenever reading
	task automatic pin_gate(input logic on);
		@(posedge pclk);
		write_gate_n <= !on;
	endtask

	// Head engage request for the head load option
	task automatic pin_engage(input logic on);
		@(posedge pclk);
		head_engage_n <= !on;
	endtask

	// Side line choosing head 0 or head 1
	task automatic pin_side(input logic v);
		@(posedge pclk);
		side <= v;
	endtask

	// Raw read comparator level
	task automatic pin_comp(input logic v);
		@(posedge pclk);
		comparator <= v;
	endtask

	// One encoded write pulse, long enough to be sampled
	task automatic wpulse();
		@(posedge pclk);
		write_data_n <= 1'b0;
		repeat (3) @(posedge pclk);
		write_data_n <= 1'b1;
		repeat (3) @(posedge pclk);
	endtask
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench of the read/write channel controller
`timescale 1ns/1ps
`include "frw_defs.svh"
module testbench;
	import frw_pkg::*;
	localparam int RDC = 40;
	localparam int TDC = 8;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [`FRW_ADDR_W-1:0] paddr = '0;
	frw_word_t pwdata = '0;
	frw_word_t prdata;
	logic pready;
	logic pslverr;
	logic notch_open = 1'b1;
	logic supply_fail_flag = 1'b0;
	logic write_gate_n, select_n, write_data_n, head_engage_n, side;
	logic comparator, write_path_enable_n, head_w1_on, head_w2_on;
	logic erase_drive_enable_n, erase_current_on, read_enable;
	logic read_connect, head_select, head_load, read_data_n;
	logic power_up_init_n, activity_latch;
	int n_mismatch = 0;
	int total_checks = 0;
	frw_word_t rd;
	logic err;
	logic seen;
	logic exp;
	int w;

	always #5 pclk = ~pclk;

	frw_channel #(.INIT_CYC(20), .ERASE_DLY_CYC(10), .TD_CYC(TDC),
		.RD_PULSE_CYC(RDC)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .write_gate_n(write_gate_n),
		.select_n(select_n), .write_data_n(write_data_n),
		.head_engage_n(head_engage_n), .side(side),
		.notch_open(notch_open), .comparator(comparator),
		.supply_fail_flag(supply_fail_flag),
		.write_path_enable_n(write_path_enable_n),
		.head_w1_on(head_w1_on), .head_w2_on(head_w2_on),
		.erase_drive_enable_n(erase_drive_enable_n),
		.erase_current_on(erase_current_on), .read_enable(read_enable),
		.read_connect(read_connect), .head_select(head_select),
		.head_load(head_load), .read_data_n(read_data_n),
		.power_up_init_n(power_up_init_n),
		.activity_latch(activity_latch));

	frw_host_model host (.pclk(pclk), .write_gate_n(write_gate_n),
		.select_n(select_n), .write_data_n(write_data_n),
		.head_engage_n(head_engage_n), .side(side),
		.comparator(comparator));

	////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic end_sim();
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Single-bit comparison
	task automatic chk_bit(input logic got, input logic e);
		total_checks++;
		if (got !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask

	// Register word comparison
	task automatic chk_word(input frw_word_t got, input frw_word_t e);
		total_checks++;
		if (got !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask

	// One APB transfer; read data and error taken at the pready edge
	task automatic apb(input logic wr, input logic [11:0] a,
		input frw_word_t d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Access phase held until pready is seen high at a rising edge
		for (i = 0; i < 50; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 50) begin
			n_mismatch++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Waits for one read pulse and measures its low width
	task automatic rd_pulse(output int wd);
		int i;
		wd = 0;
		for (i = 0; i < 600 && read_data_n !== 1'b0; i++) @(negedge pclk);
		if (i == 600) begin
			n_mismatch++;
			end_sim();
		end
		while (read_data_n === 1'b0 && wd < 600) begin
			@(negedge pclk);
			wd++;
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk_bit(power_up_init_n, 1'b0);
		chk_bit(head_w1_on | head_w2_on, 1'b0);
		apb(1'b0, `FRW_OFF_CTRL, 32'h0);
		chk_word(rd, 32'(`FRW_CTRL_RST));
		chk_bit(err, 1'b0);
		apb(1'b0, `FRW_OFF_STATUS, 32'h0);
		chk_bit(rd[`FRW_ST_INIT], 1'b1);
		repeat (30) @(posedge pclk);
		chk_bit(power_up_init_n, 1'b1);
		chk_bit(activity_latch, 1'b0);
		apb(1'b0, 12'h008, 32'h0);
		chk_bit(err, 1'b1);
		chk_word(rd, 32'h0);
		apb(1'b1, `FRW_OFF_CTRL, 32'h3);
		apb(1'b0, `FRW_OFF_CTRL, 32'h0);
		chk_word(rd, 32'h3);
		// Head load from engage, then from select
		host.pin_sel(1'b1);
		repeat (6) @(posedge pclk);
		chk_bit(head_load, 1'b0);
		host.pin_engage(1'b1);
		repeat (6) @(posedge pclk);
		chk_bit(head_load, 1'b1);
		host.pin_engage(1'b0);
		apb(1'b1, `FRW_OFF_CTRL, 32'h0);
		repeat (6) @(posedge pclk);
		chk_bit(head_load, 1'b1);
		for (int v = 1; v >= 0; v--) begin
			host.pin_side(v[0]);
			repeat (6) @(posedge pclk);
			chk_bit(head_select, v[0]);
		end
		// Write enable qualified by gate, select and protection
		host.pin_gate(1'b1);
		repeat (6) @(posedge pclk);
		chk_bit(write_path_enable_n, 1'b0);
		chk_bit(read_enable, 1'b0);
		chk_bit(read_connect, 1'b0);
		chk_bit(head_w2_on, 1'b1);
		host.pin_sel(1'b0);
		repeat (6) @(posedge pclk);
		chk_bit(write_path_enable_n, 1'b1);
		host.pin_sel(1'b1);
		@(posedge pclk);
		notch_open <= 1'b0;
		repeat (6) @(posedge pclk);
		chk_bit(write_path_enable_n, 1'b1);
		apb(1'b1, `FRW_OFF_CTRL, 32'h2);
		repeat (6) @(posedge pclk);
		chk_bit(write_path_enable_n, 1'b0);
		// Fresh write window: erase follows after the delay
		host.pin_gate(1'b0);
		repeat (20) @(posedge pclk);
		host.pin_gate(1'b1);
		repeat (5) @(posedge pclk);
		chk_bit(erase_drive_enable_n, 1'b1);
		repeat (12) @(posedge pclk);
		chk_bit(erase_drive_enable_n, 1'b0);
		chk_bit(erase_current_on, 1'b1);
		exp = 1'b1;
		repeat (3) begin
			host.wpulse();
			repeat (2) @(posedge pclk);
			chk_bit(head_w1_on, exp);
			chk_bit(head_w2_on, !exp);
			exp = !exp;
		end
		@(posedge pclk);
		supply_fail_flag <= 1'b1;
		repeat (6) @(posedge pclk);
		chk_bit(head_w1_on | head_w2_on, 1'b0);
		chk_bit(erase_current_on, 1'b0);
		supply_fail_flag <= 1'b0;
		host.pin_gate(1'b0);
		repeat (6) @(posedge pclk);
		chk_bit(read_enable, 1'b1);
		chk_bit(read_connect, 1'b1);
		repeat (15) @(posedge pclk);
		chk_bit(erase_drive_enable_n, 1'b1);
		// Read pulses on both comparator directions
		for (int v = 1; v >= 0; v--) begin
			host.pin_comp(v[0]);
			rd_pulse(w);
			chk_word(32'(w), 32'(RDC));
		end
		// Short crossing must not reach the filter
		seen = 1'b0;
		host.pin_comp(1'b1);
		repeat (3) @(posedge pclk);
		host.pin_comp(1'b0);
		repeat (TDC + 60) begin
			@(negedge pclk);
			if (read_data_n !== 1'b1) seen = 1'b1;
		end
		chk_bit(seen, 1'b0);
		// Transitions faster than pulses: buffer fills, overflow sticks
		for (int v = 0; v < 5; v++) begin
			host.pin_comp(!v[0]);
			repeat (TDC + 4) @(posedge pclk);
		end
		apb(1'b0, `FRW_OFF_STATUS, 32'h0);
		chk_bit(rd[`FRW_ST_OVF], 1'b1);
		apb(1'b1, `FRW_OFF_STATUS, 32'h1 << `FRW_ST_OVF);
		apb(1'b0, `FRW_OFF_STATUS, 32'h0);
		chk_bit(rd[`FRW_ST_OVF], 1'b0);
		repeat (300) @(posedge pclk);
		chk_bit(activity_latch, 1'b1);
		// Mid-run reset: init pulse clears latch, erase and write FF
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk_bit(power_up_init_n, 1'b0);
		chk_bit(activity_latch, 1'b0);
		chk_bit(erase_drive_enable_n, 1'b1);
		apb(1'b0, `FRW_OFF_STATUS, 32'h0);
		chk_bit(rd[`FRW_ST_WFF], 1'b0);
		chk_bit(rd[`FRW_ST_INIT], 1'b1);
		repeat (30) @(posedge pclk);
		chk_bit(power_up_init_n, 1'b1);
		end_sim();
	end
endmodule
